// [rtl/rs485_modbus_slave_settings.sv]
`timescale 1ns/10ps
`default_nettype none
module rs485_modbus_slave_settings #(
    parameter int unsigned CLK_HZ = rs485_pkg::CLK_RATE_HZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // received frames
    input wire logic rxFrameValid,
    input wire logic [7:0] rxFrameAddr,
    input wire logic rxWriteReq,
    input wire logic [7:0] rxRegNum,
    input wire logic [15:0] rxRegData,
    // frame handling results
    output logic frameForUs,
    output logic frameDiscard,
    output logic cfgWrStrobe,
    output logic [7:0] cfgWrReg,
    output logic [15:0] cfgWrData,
    output logic writeRefused,
    output logic replyGo,
    // outputs under remote control
    input wire logic [3:0] relayLocal,
    input wire logic [15:0] aoutNormal,
    output logic alertState,
    output logic [3:0] relayOut,
    output logic [15:0] aoutLevel,
    // interrupt
    output logic irq
);
    typedef struct packed {
        rs485_pkg::cfg_word_t cfg;
        rs485_pkg::fault_word_t fault;
        logic [rs485_pkg::EVT_W-1:0] status;
        logic [rs485_pkg::EVT_W-1:0] mask;
        logic [15:0] remoteAout;
        logic [3:0] remoteRelay;
        logic [31:0] preCnt;
        logic [6:0] gapSec;
        logic alert;
        logic dphWrite;
        logic [7:0] dphAddr;
        logic [31:0] rdata;
        logic readyOut;
        logic reply_delay_select;
        logic forUs;
        logic discard;
        logic wrStrobe;
        logic [7:0] wrReg;
        logic [15:0] wrData;
        logic refused;
        logic delayStart;
        logic [7:0] delayChars;
        logic replyGo;
        logic [3:0] relayOut;
        logic [15:0] aout;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [rs485_pkg::EVT_W-1:0] evt;
    logic [rs485_pkg::EVT_W-1:0] clr;
    logic hit;
    logic alwaysWritable;
    logic [3:0] relaySrc;
    rs485_pkg::cfg_word_t cfgIn;
    rs485_pkg::fault_word_t faultIn;

    reply_delay_if rd ();

    function automatic logic addrMatch(input logic [7:0] station, input logic [7:0] addr);
        if (station == 8'h00) begin
            return addr == rs485_pkg::ZERO_SUBST_ADDR;
        end
        return addr == station;
    endfunction

    always_comb begin
        s_d = s_q;
        evt = '0;
        clr = '0;
        cfgIn = rs485_pkg::cfg_word_t'(hwdata);
        faultIn = rs485_pkg::fault_word_t'(hwdata);
        s_d.forUs = 1'b0;
        s_d.discard = 1'b0;
        s_d.wrStrobe = 1'b0;
        s_d.refused = 1'b0;
        s_d.delayStart = 1'b0;
        s_d.replyGo = rd.done;
        hit = rxFrameValid && addrMatch(s_q.cfg.station, rxFrameAddr);
        alwaysWritable = rxRegNum == rs485_pkg::REMOTE_AOUT_REG
            || rxRegNum == rs485_pkg::REMOTE_RELAY_REG;

        // bus write data phase
        if (s_q.dphWrite) begin
            if (s_q.dphAddr == rs485_pkg::CFG_OFF) begin
                if (cfgIn.station <= rs485_pkg::MAX_STATION) begin
                    s_d.cfg.station = cfgIn.station;
                end
                s_d.cfg.baudSel = cfgIn.baudSel;
                s_d.cfg.remoteConfigPermit = cfgIn.remoteConfigPermit;
                if (cfgIn.frameGapLimit <= rs485_pkg::MAX_GAP_S) begin
                    s_d.cfg.frameGapLimit = cfgIn.frameGapLimit;
                end
                s_d.cfg.replyDelaySelect = cfgIn.replyDelaySelect;
                s_d.cfg.relayRemote = cfgIn.relayRemote;
                s_d.cfg.aoutRemote = cfgIn.aoutRemote;
            end else if (s_q.dphAddr == rs485_pkg::MASK_OFF) begin
                s_d.mask = hwdata[rs485_pkg::EVT_W-1:0];
            end else if (s_q.dphAddr == rs485_pkg::FAULT_OFF) begin
                s_d.fault = faultIn;
                s_d.fault.pad = '0;
            end
        end

        // bus address phase, read data registered for the data phase
        s_d.dphWrite = 1'b0;
        if (hsel && htrans[1] && hready) begin
            s_d.dphWrite = hwrite;
            s_d.dphAddr = haddr[7:0];
            s_d.rdata = 32'h0;
            if (!hwrite) begin
                if (haddr[7:0] == rs485_pkg::CFG_OFF) begin
                    s_d.rdata = s_q.cfg;
                end else if (haddr[7:0] == rs485_pkg::STATUS_OFF) begin
                    s_d.rdata = {27'h0, s_q.status};
                    clr = s_q.status;
                end else if (haddr[7:0] == rs485_pkg::MASK_OFF) begin
                    s_d.rdata = {27'h0, s_q.mask};
                end else if (haddr[7:0] == rs485_pkg::FAULT_OFF) begin
                    s_d.rdata = s_q.fault;
                end else if (haddr[7:0] == rs485_pkg::STATE_OFF) begin
                    s_d.rdata = {20'h0, s_q.remoteRelay, s_q.gapSec, s_q.alert};
                end else if (haddr[7:0] == rs485_pkg::REMOTE_OFF) begin
                    s_d.rdata = {16'h0, s_q.remoteAout};
                end
            end
        end

        // frame gap watchdog, any received frame restarts it
        if (rxFrameValid || s_q.cfg.frameGapLimit == 7'h00) begin
            s_d.preCnt = 32'h0;
            s_d.gapSec = 7'h00;
            s_d.alert = 1'b0;
        end else if (s_q.preCnt == 32'(CLK_HZ - 1)) begin
            s_d.preCnt = 32'h0;
            if (s_q.gapSec != rs485_pkg::GAP_SAT) begin
                s_d.gapSec = s_q.gapSec + 7'h01;
            end
            if (s_q.gapSec + 7'h01 >= s_q.cfg.frameGapLimit) begin
                s_d.alert = 1'b1;
                evt[rs485_pkg::EVT_ALERT] = !s_q.alert;
            end
        end else begin
            s_d.preCnt = s_q.preCnt + 32'h1;
        end

        // frame address filter and serial register writes
        if (hit) begin
            s_d.forUs = 1'b1;
            s_d.delayStart = 1'b1;
            s_d.delayChars = rs485_pkg::REPLY_CHARS[s_q.cfg.replyDelaySelect];
            evt[rs485_pkg::EVT_FOR_US] = 1'b1;
            if (rxWriteReq) begin
                if (s_q.cfg.remoteConfigPermit || alwaysWritable) begin
                    s_d.wrStrobe = 1'b1;
                    s_d.wrReg = rxRegNum;
                    s_d.wrData = rxRegData;
                    evt[rs485_pkg::EVT_WRITE] = 1'b1;
                    if (rxRegNum == rs485_pkg::REMOTE_AOUT_REG) begin
                        s_d.remoteAout = rxRegData;
                    end
                    if (rxRegNum == rs485_pkg::REMOTE_RELAY_REG) begin
                        s_d.remoteRelay = rxRegData[3:0];
                    end
                end else begin
                    s_d.refused = 1'b1;
                    evt[rs485_pkg::EVT_REFUSED] = 1'b1;
                end
            end
        end else if (rxFrameValid) begin
            s_d.discard = 1'b1;
            evt[rs485_pkg::EVT_DISCARD] = 1'b1;
        end

        // remote outputs, alert overrides the remote values
        relaySrc = s_d.alert ? s_q.fault.relayAlert : s_q.remoteRelay;
        s_d.relayOut = (s_q.cfg.relayRemote & relaySrc) | (~s_q.cfg.relayRemote & relayLocal);
        if (s_d.alert && s_q.fault.faultHold) begin
            s_d.aout = s_q.aout;
        end else if (s_d.alert) begin
            s_d.aout = s_q.fault.faultOutputLevel;
        end else if (s_q.cfg.aoutRemote) begin
            s_d.aout = s_q.remoteAout;
        end else begin
            s_d.aout = aoutNormal;
        end

        // sticky status, a new event wins over the read clear
        s_d.status = (s_q.status & ~clr) | evt;
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
            s_q.cfg <= rs485_pkg::CFG_RESET;
            s_q.readyOut <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd.start = s_q.delayStart;
    assign rd.baudSel = s_q.cfg.baudSel;
    assign rd.nChars = s_q.delayChars;

    rs_char_timer #(
        .CLK_HZ(CLK_HZ)
    ) charTimer (
        .mclk(mclk),
        .srst(srst),
        .rd(rd)
    );

    assign hreadyout = s_q.readyOut;
    assign hresp = s_q.reply_delay_select;
    assign hrdata = s_q.rdata;
    assign frameForUs = s_q.forUs;
    assign frameDiscard = s_q.discard;
    assign cfgWrStrobe = s_q.wrStrobe;
    assign cfgWrReg = s_q.wrReg;
    assign cfgWrData = s_q.wrData;
    assign writeRefused = s_q.refused;
    assign replyGo = s_q.replyGo;
    assign alertState = s_q.alert;
    assign relayOut = s_q.relayOut;
    assign aoutLevel = s_q.aout;
    assign irq = s_q.irq;

    station_match_a: assert property (@(posedge mclk) disable iff (srst)
        rxFrameValid && s_q.cfg.station != 8'h00 && rxFrameAddr == s_q.cfg.station
        |=> frameForUs && !frameDiscard)
        else $error("frame for own station not taken");

    zero_station_a: assert property (@(posedge mclk) disable iff (srst)
        rxFrameValid && s_q.cfg.station == 8'h00 && rxFrameAddr == 8'hff |=> frameForUs)
        else $error("station zero did not take address 255");

    foreign_drop_a: assert property (@(posedge mclk) disable iff (srst)
        rxFrameValid && !addrMatch(s_q.cfg.station, rxFrameAddr)
        |=> frameDiscard && !frameForUs && !cfgWrStrobe ##1 !replyGo [*3])
        else $error("foreign frame not discarded");

    locked_write_a: assert property (@(posedge mclk) disable iff (srst)
        hit && rxWriteReq && !s_q.cfg.remoteConfigPermit && !alwaysWritable
        |=> writeRefused && !cfgWrStrobe)
        else $error("locked config write not refused");

    open_regs_a: assert property (@(posedge mclk) disable iff (srst)
        hit && rxWriteReq && alwaysWritable |=> cfgWrStrobe && cfgWrReg == $past(rxRegNum))
        else $error("register 04h or 05h write lost");

    gap_off_a: assert property (@(posedge mclk) disable iff (srst)
        s_q.cfg.frameGapLimit == 7'h00 |=> !alertState)
        else $error("alert raised with watchdog off");

    gap_alert_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(alertState) |-> s_q.gapSec >= s_q.cfg.frameGapLimit && !$past(rxFrameValid))
        else $error("alert raised before gap limit");

    std_reply_a: assert property (@(posedge mclk) disable iff (srst)
        frameForUs && s_q.delayChars == 8'h00 |-> ##2 replyGo)
        else $error("standard reply not immediate");

    alert_level_a: assert property (@(posedge mclk) disable iff (srst)
        alertState && !$past(srst) && !$past(s_q.fault.faultHold)
        |-> aoutLevel == $past(s_q.fault.faultOutputLevel))
        else $error("analogue output not at alert level");

    remote_aout_a: assert property (@(posedge mclk) disable iff (srst)
        !alertState && !$past(srst) && $past(s_q.cfg.aoutRemote)
        |-> aoutLevel == $past(s_q.remoteAout))
        else $error("remote analogue value not applied");

    normal_aout_a: assert property (@(posedge mclk) disable iff (srst)
        !alertState && !$past(srst) && !$past(s_q.cfg.aoutRemote)
        |-> aoutLevel == $past(aoutNormal))
        else $error("analogue output not back to normal value");

endmodule
`default_nettype wire

// [rtl/rs485_pkg.sv]
`default_nettype none
package rs485_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned NS_PER_S = 1000000000;
    localparam int unsigned CLK_RATE_HZ = NS_PER_S / CLK_PERIOD_NS;

    // line rates and character framing
    localparam int unsigned BAUD_COUNT = 8;
    localparam int unsigned BAUD_RATE [BAUD_COUNT] = '{
        1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200
    };
    localparam int unsigned CHAR_BITS = 11;

    // reply delay in character times, index is the reply delay select
    localparam logic [7:0] REPLY_CHARS [8] = '{
        8'h00, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8, 8'h00, 8'h00
    };

    // station address
    localparam logic [7:0] MAX_STATION = 8'hc7;
    localparam logic [7:0] ZERO_SUBST_ADDR = 8'hff;

    // frame gap limit
    localparam logic [6:0] MAX_GAP_S = 7'h63;
    localparam logic [6:0] GAP_SAT = 7'h7f;

    // serial registers that stay writable when remote config is locked
    localparam logic [7:0] REMOTE_AOUT_REG = 8'h04;
    localparam logic [7:0] REMOTE_RELAY_REG = 8'h05;

    // bus register byte offsets
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] MASK_OFF = 8'h08;
    localparam logic [7:0] FAULT_OFF = 8'h0c;
    localparam logic [7:0] STATE_OFF = 8'h10;
    localparam logic [7:0] REMOTE_OFF = 8'h14;

    // status bit positions
    localparam int unsigned EVT_W = 5;
    localparam int unsigned EVT_FOR_US = 0;
    localparam int unsigned EVT_DISCARD = 1;
    localparam int unsigned EVT_REFUSED = 2;
    localparam int unsigned EVT_ALERT = 3;
    localparam int unsigned EVT_WRITE = 4;

    typedef struct packed {
        logic [4:0] pad;
        logic aoutRemote;
        logic [3:0] relayRemote;
        logic [2:0] replyDelaySelect;
        logic [6:0] frameGapLimit;
        logic remoteConfigPermit;
        logic [2:0] baudSel;
        logic [7:0] station;
    } cfg_word_t;

    typedef struct packed {
        logic [10:0] pad;
        logic [3:0] relayAlert;
        logic faultHold;
        logic [15:0] faultOutputLevel;
    } fault_word_t;

    localparam cfg_word_t CFG_RESET = '{
        pad: 5'h00, aoutRemote: 1'b0, relayRemote: 4'h0, replyDelaySelect: 3'h0,
        frameGapLimit: 7'h00, remoteConfigPermit: 1'b1, baudSel: 3'h3, station: 8'h01
    };

    typedef enum logic {TIMER_IDLE, TIMER_RUN} timer_state_t;

endpackage
`default_nettype wire

// [rtl/reply_delay_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface reply_delay_if;
    logic start;
    logic [2:0] baudSel;
    logic [7:0] nChars;
    logic done;
    modport ctrl (output start, output baudSel, output nChars, input done);
    modport timer (input start, input baudSel, input nChars, output done);
endinterface
`default_nettype wire

// [rtl/rs_char_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module rs_char_timer #(
    parameter int unsigned CLK_HZ = rs485_pkg::CLK_RATE_HZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // delay request
    reply_delay_if.timer rd
);
    typedef struct packed {
        rs485_pkg::timer_state_t state;
        logic [31:0] cycCnt;
        logic [31:0] charCycles;
        logic [7:0] charCnt;
        logic [7:0] chars;
        logic done;
    } timer_t;

    timer_t t_q;
    timer_t t_d;

    function automatic logic [31:0] bitCycles(input logic [2:0] sel);
        int unsigned q;
        q = CLK_HZ / rs485_pkg::BAUD_RATE[sel];
        if (q < 1) begin
            q = 1;
        end
        return 32'(q);
    endfunction

    always_comb begin
        t_d = t_q;
        t_d.done = 1'b0;
        case (t_q.state)
            rs485_pkg::TIMER_IDLE: begin
            end
            rs485_pkg::TIMER_RUN: begin
                if (t_q.cycCnt == t_q.charCycles - 32'h1) begin
                    t_d.cycCnt = 32'h0;
                    if (t_q.charCnt == t_q.chars - 8'h1) begin
                        t_d.done = 1'b1;
                        t_d.state = rs485_pkg::TIMER_IDLE;
                    end else begin
                        t_d.charCnt = t_q.charCnt + 8'h1;
                    end
                end else begin
                    t_d.cycCnt = t_q.cycCnt + 32'h1;
                end
            end
            default: t_d.state = rs485_pkg::TIMER_IDLE;
        endcase
        if (rd.start) begin
            t_d.chars = rd.nChars;
            t_d.cycCnt = 32'h0;
            t_d.charCnt = 8'h0;
            // one character time follows the selected line rate
            t_d.charCycles = 32'(bitCycles(rd.baudSel) * rs485_pkg::CHAR_BITS);
            if (rd.nChars == 8'h0) begin
                t_d.done = 1'b1;
                t_d.state = rs485_pkg::TIMER_IDLE;
            end else begin
                t_d.done = 1'b0;
                t_d.state = rs485_pkg::TIMER_RUN;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign rd.done = t_q.done;

    timer_wait_a: assert property (@(posedge mclk) disable iff (srst)
        rd.start && rd.nChars != 8'h0 |=> !rd.done [*8])
        else $error("delayed reply finished too early");

endmodule
`default_nettype wire

// [test/modbus_master_model.sv]
`timescale 1ns/10ps
`default_nettype none
module modbus_master_model (
    // clock
    input wire logic mclk,
    // frames toward the slave
    output logic rxFrameValid,
    output logic [7:0] rxFrameAddr,
    output logic rxWriteReq,
    output logic [7:0] rxRegNum,
    output logic [15:0] rxRegData
);
    initial begin
        rxFrameValid = 1'b0;
        rxFrameAddr = 8'h5a;
        rxWriteReq = 1'b0;
        rxRegNum = 8'ha5;
        rxRegData = 16'h5a5a;
    end

    // one whole frame, already decoded, valid for a single clock cycle
    task automatic send(input logic [7:0] a, input logic w, input logic [7:0] r,
                        input logic [15:0] d);
        @(posedge mclk);
        rxFrameValid <= 1'b1;
        rxFrameAddr <= a;
        rxWriteReq <= w;
        rxRegNum <= r;
        rxRegData <= d;
        @(posedge mclk);
        // fields no longer valid: show the inverse
        rxFrameValid <= 1'b0;
        rxFrameAddr <= ~a;
        rxWriteReq <= ~w;
        rxRegNum <= ~r;
        rxRegData <= ~d;
    endtask
endmodule
`default_nettype wire

// [test/test_rs485_modbus_slave_settings.sv]
`timescale 1ns/10ps
`default_nettype none
module test_rs485_modbus_slave_settings;
    localparam int unsigned HZ = 20000;
    localparam int CEILING = 80000;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, rxFrameValid, rxWriteReq;
    logic [31:0] hrdata;
    logic [7:0] rxFrameAddr, rxRegNum, cfgWrReg;
    logic [15:0] rxRegData, cfgWrData, aoutLevel;
    logic frameForUs, frameDiscard, cfgWrStrobe, writeRefused, replyGo, alertState, irq;
    logic [3:0] relayOut;
    logic [3:0] relayLocal = 4'ha;
    logic [15:0] aoutNormal = 16'h5555;
    int miscompares = 0;
    int checksDone = 0;
    int cycles = 0;

    always #4 mclk = ~mclk;

    rs485_modbus_slave_settings #(.CLK_HZ(HZ)) rs485_modbus_slave_settings_i (
        .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rxFrameValid(rxFrameValid), .rxFrameAddr(rxFrameAddr), .rxWriteReq(rxWriteReq),
        .rxRegNum(rxRegNum), .rxRegData(rxRegData), .frameForUs(frameForUs),
        .frameDiscard(frameDiscard), .cfgWrStrobe(cfgWrStrobe), .cfgWrReg(cfgWrReg),
        .cfgWrData(cfgWrData), .writeRefused(writeRefused), .replyGo(replyGo),
        .relayLocal(relayLocal), .aoutNormal(aoutNormal), .alertState(alertState),
        .relayOut(relayOut), .aoutLevel(aoutLevel), .irq(irq)
    );

    modbus_master_model modbus_master_model_i (
        .mclk(mclk), .rxFrameValid(rxFrameValid), .rxFrameAddr(rxFrameAddr),
        .rxWriteReq(rxWriteReq), .rxRegNum(rxRegNum), .rxRegData(rxRegData)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == CEILING) begin
            miscompares++;
            summarize();
        end
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        cmp(nm, e, x);
    endtask

    function automatic logic [31:0] mkcfg(input logic [7:0] st, input logic [2:0] bd,
            input logic pm, input logic [6:0] gap, input logic [2:0] dl,
            input logic [3:0] rm, input logic ar);
        return {5'h0, ar, rm, dl, gap, pm, bd, st};
    endfunction

    // flags seen one cycle after the frame: strobe, refused, discard, for us
    task automatic frame(input logic [7:0] a, input logic w, input logic [7:0] r,
                         input logic [15:0] d, output logic [3:0] f);
        modbus_master_model_i.send(a, w, r, d);
        #1;
        f = {cfgWrStrobe, writeRefused, frameDiscard, frameForUs};
    endtask

    task automatic reply(input int lim, output int n);
        n = 1;
        while (replyGo !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    initial begin
        logic [3:0] f;
        int n;
        int bc;
        int dl;
        int chars [8] = '{0, 10, 20, 50, 100, 200, 0, 0};
        int rate [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
        logic pm [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        logic [7:0] rg [4] = '{8'h02, 8'h04, 8'h05, 8'h02};
        logic [3:0] ef [4] = '{4'h5, 4'h9, 4'h9, 4'h9};
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rdchk("cfgReset", rs485_pkg::CFG_OFF, rs485_pkg::CFG_RESET);
        cmp("hresp", 32'h0, {31'h0, hresp});
        cmp("hreadyout", 32'h1, {31'h0, hreadyout});
        rdchk("unmapped", 8'h20, 32'h0);
        wr(rs485_pkg::MASK_OFF, 32'h1f);
        rdchk("mask", rs485_pkg::MASK_OFF, 32'h1f);
        frame(8'h01, 1'b0, 8'h00, 16'h0, f);
        cmp("match", 32'h1, {28'h0, f});
        reply(10, n);
        cmp("stdReply", 32'd3, n);
        frame(8'h02, 1'b0, 8'h00, 16'h0, f);
        cmp("foreign", 32'h2, {28'h0, f});
        reply(10, n);
        cmp("noReply", 32'd10, n);
        wr(rs485_pkg::CFG_OFF, mkcfg(8'hc7, 3'h3, 1'b1, 7'h0, 3'h0, 4'h0, 1'b0));
        frame(8'hc7, 1'b0, 8'h00, 16'h0, f);
        cmp("top", 32'h1, {28'h0, f});
        wr(rs485_pkg::CFG_OFF, mkcfg(8'hc8, 3'h3, 1'b1, 7'h0, 3'h0, 4'h0, 1'b0));
        rdchk("overTop", rs485_pkg::CFG_OFF,
            mkcfg(8'hc7, 3'h3, 1'b1, 7'h0, 3'h0, 4'h0, 1'b0));
        wr(rs485_pkg::CFG_OFF, mkcfg(8'h00, 3'h3, 1'b1, 7'h0, 3'h0, 4'h0, 1'b0));
        frame(8'hff, 1'b0, 8'h00, 16'h0, f);
        cmp("zeroSubst", 32'h1, {28'h0, f});
        frame(8'h01, 1'b0, 8'h00, 16'h0, f);
        cmp("zeroOther", 32'h2, {28'h0, f});
        for (int i = 0; i < 4; i++) begin
            wr(rs485_pkg::CFG_OFF, mkcfg(8'h01, 3'h3, pm[i], 7'h0, 3'h0, 4'h0, 1'b0));
            frame(8'h01, 1'b1, rg[i], 16'h0100, f);
            cmp("permit", {28'h0, ef[i]}, {28'h0, f});
            if (f[3] === 1'b1) cmp("wrReg", {24'h0, rg[i]}, {24'h0, cfgWrReg});
            if (f[3] === 1'b1) cmp("wrData", 32'h0100, {16'h0, cfgWrData});
        end
        cmp("irqSet", 32'h1, {31'h0, irq});
        rdchk("status", rs485_pkg::STATUS_OFF, 32'h17);
        cmp("irqClr", 32'h0, {31'h0, irq});
        rdchk("statusClr", rs485_pkg::STATUS_OFF, 32'h0);
        wr(rs485_pkg::MASK_OFF, 32'h02);
        frame(8'h01, 1'b0, 8'h00, 16'h0, f);
        repeat (2) @(posedge mclk);
        #1;
        cmp("irqMasked", 32'h0, {31'h0, irq});
        frame(8'h03, 1'b0, 8'h00, 16'h0, f);
        repeat (2) @(posedge mclk);
        #1;
        cmp("irqUnmasked", 32'h1, {31'h0, irq});
        rdchk("status2", rs485_pkg::STATUS_OFF, 32'h03);
        for (int d = 0; d < 8; d++) begin
            wr(rs485_pkg::CFG_OFF, mkcfg(8'h01, 3'h3, 1'b1, 7'h0, 3'(d), 4'h0, 1'b0));
            frame(8'h01, 1'b0, 8'h00, 16'h0, f);
            reply(6000, n);
            cmp("delay", 32'(3 + chars[d] * 22), n);
        end
        for (int b = 0; b < 8; b++) begin
            bc = (HZ / rate[b] < 1) ? 1 : HZ / rate[b];
            dl = (b > 4) ? b - 4 : 1;
            wr(rs485_pkg::CFG_OFF, mkcfg(8'h01, 3'(b), 1'b1, 7'h0, 3'(dl), 4'h0, 1'b0));
            frame(8'h01, 1'b0, 8'h00, 16'h0, f);
            reply(3000, n);
            cmp("baudDelay", 32'(3 + chars[dl] * 11 * bc), n);
        end
        wr(rs485_pkg::FAULT_OFF, {11'h0, 4'h0, 1'b0, 16'h0abc});
        wr(rs485_pkg::CFG_OFF, mkcfg(8'h01, 3'h3, 1'b0, 7'h1, 3'h0, 4'h1, 1'b1));
        frame(8'h01, 1'b1, 8'h04, 16'h1234, f);
        repeat (3) @(posedge mclk);
        #1;
        cmp("aoutRemote", 32'h1234, {16'h0, aoutLevel});
        frame(8'h01, 1'b1, 8'h05, 16'h0001, f);
        repeat (3) @(posedge mclk);
        #1;
        cmp("relayRemote", 32'hb, {28'h0, relayOut});
        frame(8'h01, 1'b0, 8'h00, 16'h0, f);
        n = 0;
        while (alertState !== 1'b1 && n < 25000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        cmp("alertTime", 32'h1, {31'h0, n >= 19990 && n <= 20010});
        cmp("aoutAlert", 32'h0abc, {16'h0, aoutLevel});
        cmp("relayAlert", 32'ha, {28'h0, relayOut});
        rdchk("statusAlert", rs485_pkg::STATUS_OFF, 32'h19);
        wr(rs485_pkg::CFG_OFF, mkcfg(8'h01, 3'h3, 1'b0, 7'h1, 3'h0, 4'h1, 1'b0));
        aoutNormal <= 16'h2468;
        frame(8'h01, 1'b0, 8'h00, 16'h0, f);
        repeat (3) @(posedge mclk);
        #1;
        cmp("alertEnd", 32'h0, {31'h0, alertState});
        cmp("aoutBack", 32'h2468, {16'h0, aoutLevel});
        wr(rs485_pkg::CFG_OFF, mkcfg(8'h01, 3'h3, 1'b1, 7'h0, 3'h0, 4'h1, 1'b0));
        repeat (21000) @(posedge mclk);
        #1;
        cmp("noWatchdog", 32'h0, {31'h0, alertState});
        summarize();
    end
endmodule
`default_nettype wire
